// ---- common/gray_lut_map.svh ----
`ifndef GRAY_LUT_MAP_SVH
`define GRAY_LUT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_HWIDTH 8'h01
`define REG_VLINES 8'h02
`define REG_STATUS 8'h03
`define REG_LINE_EXTRA 8'h11
`define REG_GREEN_HI 4'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_DEPTH_LSB 1
`define CTRL_DEPTH_MSB 2
`define GREEN_LSB 4
`define GREEN_MSB 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_HWIDTH 8'h13
`define RST_VLINES 8'hEF
`define RST_LINE_EXTRA 8'h00

// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define MEM_BYTES 81920
`define WORD_BITS 16
`define MEM_WORDS (`MEM_BYTES * 8 / `WORD_BITS)
`define FIFO_DEPTH 8

`endif

// ---- common/gray_lut_pkg.sv ----
package gray_lut_pkg;

  typedef enum logic [1:0] {DEPTH_1BPP, DEPTH_2BPP, DEPTH_4BPP, DEPTH_8BPP} depth_t;

  typedef enum logic {FETCH_IDLE, FETCH_RUN} fetch_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic frame_start;
    logic line_end;
    logic [15:0] data;
  } mem_word_t;

  typedef struct packed {
    logic frame_start;
    logic line_end;
    logic [3:0] gray;
  } pixel_t;

endpackage : gray_lut_pkg

// ---- src/pixel_fifo.sv ----
`timescale 1ns/100ps

module pixel_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (32'(p) == DEPTH - 1) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready = (32'(st_ff.cnt) != DEPTH);
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = ptr_inc(st_ff.wp);
    end
    if (pop)
    begin
      nxt_st.rp = ptr_inc(st_ff.rp);
    end
    if (push && !pop)
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  property p_no_lost_push;
    @(posedge clk) disable iff (!rst_n)
    in_valid |-> in_ready;
  endproperty
  a_no_lost_push: assert property (p_no_lost_push) else $error("word offered to full fifo");

endmodule : pixel_fifo

// ---- src/gray_pixel_fetch.sv ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "gray_lut_map.svh"

// What this block does
// RULE1: gray level comes only from the green part of the chosen table entry
// RULE2: gray depth offered only at 1, 2 and 4 bits; 8 bits refused
// RULE3: at 1 bit per pixel only the first two green entries are used
// RULE4: each green entry holds one of sixteen levels, black to white
// RULE5: 1 bit per pixel: byte gives eight pixels, bit picks entry 0 or 1
// RULE6: 2 bits per pixel: byte gives four pixels, codes pick entries 0 to 3
// RULE7: at 2 bits per pixel entries above the first four never show
// RULE8: 4 bits per pixel: byte gives two pixels, nibble picks entries 0 to 15
// RULE9: 8-bit line extra word count, 0 to 255 words
// RULE10: extra count zero means lines follow directly in memory
// RULE11: extra count never changes the visible words per line
// RULE12: display memory is 81920 bytes; addresses wrap inside it
// RULE13: a memory word is 16 bits; pixels per word is 16 over depth
// RULE14: next line address is line start plus visible words plus extra words
// RULE15: inside a byte the most significant group is the leftmost pixel
module gray_pixel_fetch
  import gray_lut_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire bus_req_t bus,
  output logic [7:0] rd_data,
  // Display memory, data one cycle after the read strobe
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  // Panel pixel stream
  output logic pix_valid,
  input wire logic pix_ready,
  output pixel_t pix
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic en;
    depth_t depth;
    logic [7:0] hwidth;
    logic [7:0] vlines;
    logic [7:0] extra;
    logic [15:0][3:0] green;
    logic [7:0] rdata;
    fetch_st_t fst;
    logic [15:0] line_base;
    logic [15:0] addr;
    logic [7:0] word_cnt;
    logic [7:0] line_cnt;
    logic frame_first;
    logic pend;
    logic pend_first;
    logic pend_last;
    logic [15:0] sh;
    logic [4:0] left;
    logic sh_first;
    logic sh_last;
    pixel_t out;
    logic out_v;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_s_n;
  mem_word_t fifo_in;
  mem_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic issue;
  logic last_word;
  logic frame_end;
  logic take_pix;
  logic pop;
  logic [3:0] cur_idx;
  logic [3:0] sel_green;
  logic [15:0] step_target;
  logic [3:0] pop_hi;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] px_per_word(input depth_t d);
    px_per_word = 5'(`WORD_BITS >> d);
  endfunction : px_per_word

  function automatic logic [4:0] bits_per_px(input depth_t d);
    bits_per_px = 5'h01 << d;
  endfunction : bits_per_px

  function automatic logic [3:0] px_index(input depth_t d, input logic [15:0] s);
    case (d)
      DEPTH_1BPP: px_index = {3'h0, s[15]};
      DEPTH_2BPP: px_index = {2'h0, s[15:14]};
      default: px_index = s[15:12];
    endcase
  endfunction : px_index

  function automatic logic [15:0] wrap_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 17'(`MEM_WORDS))
    begin
      s = s - 17'(`MEM_WORDS);
    end
    wrap_add = s[15:0];
  endfunction : wrap_add

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync_ff <= 2'h0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_s_n = rst_sync_ff[1];

  // ----------------------------------------
  // Word buffer
  // ----------------------------------------
  pixel_fifo #(
    .WIDTH($bits(mem_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_s_n),
    .in_valid(st_ff.pend),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  assign fifo_in = '{frame_start: st_ff.pend_first, line_end: st_ff.pend_last,
                     data: mem_rdata};
  assign issue = (st_ff.fst == FETCH_RUN) && fifo_in_ready && !st_ff.pend;
  assign mem_rd = issue;
  assign mem_addr = st_ff.addr;
  assign last_word = (st_ff.word_cnt == st_ff.hwidth);
  assign frame_end = last_word && (st_ff.line_cnt == st_ff.vlines);
  assign step_target = wrap_add(st_ff.line_base,
                                16'(st_ff.hwidth) + 16'h0001 + 16'(st_ff.extra));
  assign fifo_out_ready = (st_ff.left == 5'h00);
  assign pop = fifo_out_valid && fifo_out_ready;
  assign take_pix = (!st_ff.out_v || pix_ready) && (st_ff.left != 5'h00);
  assign cur_idx = px_index(st_ff.depth, st_ff.sh);
  assign sel_green = st_ff.green[cur_idx];
  assign pop_hi = fifo_out.data[7:4];
  assign rd_data = st_ff.rdata;
  assign pix_valid = st_ff.out_v;
  assign pix = st_ff.out;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    // Register writes
    if (bus.wr)
    begin
      case (bus.addr)
        `REG_CTRL:
        begin
          nxt_st.en = bus.wdata[`CTRL_EN_BIT];
          if (bus.wdata[`CTRL_DEPTH_MSB:`CTRL_DEPTH_LSB] != DEPTH_8BPP) // see RULE2
          begin
            nxt_st.depth = depth_t'(bus.wdata[`CTRL_DEPTH_MSB:`CTRL_DEPTH_LSB]);
          end
        end
        `REG_HWIDTH: nxt_st.hwidth = bus.wdata;
        `REG_VLINES: nxt_st.vlines = bus.wdata;
        `REG_LINE_EXTRA: nxt_st.extra = bus.wdata; // see RULE9
        default:
        begin
          if (bus.addr[7:4] == `REG_GREEN_HI)
          begin
            nxt_st.green[bus.addr[3:0]] = bus.wdata[`GREEN_MSB:`GREEN_LSB]; // see RULE4
          end
        end
      endcase
    end
    // Register reads
    if (bus.rd)
    begin
      case (bus.addr)
        `REG_CTRL: nxt_st.rdata = {5'h00, st_ff.depth, st_ff.en};
        `REG_HWIDTH: nxt_st.rdata = st_ff.hwidth;
        `REG_VLINES: nxt_st.rdata = st_ff.vlines;
        `REG_STATUS: nxt_st.rdata = {6'h00, st_ff.out_v, st_ff.fst == FETCH_RUN};
        `REG_LINE_EXTRA: nxt_st.rdata = st_ff.extra; // see RULE9
        default:
        begin
          if (bus.addr[7:4] == `REG_GREEN_HI)
          begin
            nxt_st.rdata = {st_ff.green[bus.addr[3:0]], 4'h0};
          end
        end
      endcase
    end
    // Memory fetch
    nxt_st.pend = issue;
    case (st_ff.fst)
      FETCH_IDLE:
      begin
        if (st_ff.en)
        begin
          nxt_st.fst = FETCH_RUN;
          nxt_st.addr = 16'h0000;
          nxt_st.line_base = 16'h0000;
          nxt_st.word_cnt = 8'h00;
          nxt_st.line_cnt = 8'h00;
          nxt_st.frame_first = 1'b1;
        end
      end
      FETCH_RUN:
      begin
        if (issue)
        begin
          nxt_st.pend_first = st_ff.frame_first;
          nxt_st.pend_last = last_word;
          nxt_st.frame_first = 1'b0;
          if (frame_end)
          begin
            nxt_st.word_cnt = 8'h00;
            nxt_st.line_cnt = 8'h00;
            nxt_st.line_base = 16'h0000;
            nxt_st.addr = 16'h0000;
            nxt_st.frame_first = 1'b1;
            nxt_st.fst = st_ff.en ? FETCH_RUN : FETCH_IDLE;
          end
          else if (last_word)
          begin
            nxt_st.word_cnt = 8'h00;
            nxt_st.line_cnt = st_ff.line_cnt + 8'h01;
            nxt_st.line_base = step_target; // see RULE14, see RULE10, see RULE11
            nxt_st.addr = step_target; // see RULE12
          end
          else
          begin
            nxt_st.word_cnt = st_ff.word_cnt + 8'h01;
            nxt_st.addr = wrap_add(st_ff.addr, 16'h0001); // see RULE12
          end
        end
      end
      default: nxt_st.fst = FETCH_IDLE;
    endcase
    // Pixel output
    if (st_ff.out_v && pix_ready)
    begin
      nxt_st.out_v = 1'b0;
    end
    if (take_pix)
    begin
      nxt_st.out.gray = sel_green; // see RULE1, see RULE3, see RULE7
      nxt_st.out.frame_start = st_ff.sh_first && (st_ff.left == px_per_word(st_ff.depth));
      nxt_st.out.line_end = st_ff.sh_last && (st_ff.left == 5'h01);
      nxt_st.out_v = 1'b1;
      nxt_st.sh = st_ff.sh << bits_per_px(st_ff.depth); // see RULE15
      nxt_st.left = st_ff.left - 5'h01;
    end
    if (pop)
    begin
      // Low address byte shows first, top bits leftmost
      nxt_st.sh = {fifo_out.data[7:0], fifo_out.data[15:8]}; // see RULE15, see RULE5
      nxt_st.left = px_per_word(st_ff.depth); // see RULE13, see RULE6, see RULE8
      nxt_st.sh_first = fifo_out.frame_start;
      nxt_st.sh_last = fifo_out.line_end;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      st_ff <= '{en: 1'b0, depth: DEPTH_1BPP, hwidth: `RST_HWIDTH, vlines: `RST_VLINES,
                 extra: `RST_LINE_EXTRA, fst: FETCH_IDLE, default: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_green_only;
    @(posedge clk) disable iff (!rst_s_n)
    take_pix |=> pix_valid && (pix.gray == $past(sel_green));
  endproperty
  a_green_only: assert property (p_green_only) else $error("gray not from green entry"); // see RULE1

  property p_no_8bpp;
    @(posedge clk) disable iff (!rst_s_n)
    (bus.wr && bus.addr == `REG_CTRL) |=> st_ff.depth != DEPTH_8BPP;
  endproperty
  a_no_8bpp: assert property (p_no_8bpp) else $error("8 bit gray depth accepted"); // see RULE2

  property p_one_bpp_idx;
    @(posedge clk) disable iff (!rst_s_n)
    (take_pix && st_ff.depth == DEPTH_1BPP) |-> cur_idx < 4'h2;
  endproperty
  a_one_bpp_idx: assert property (p_one_bpp_idx) else $error("1 bit index beyond 1"); // see RULE3, see RULE5

  property p_two_bpp_idx;
    @(posedge clk) disable iff (!rst_s_n)
    (take_pix && st_ff.depth == DEPTH_2BPP) |-> cur_idx < 4'h4;
  endproperty
  a_two_bpp_idx: assert property (p_two_bpp_idx) else $error("2 bit index beyond 3"); // see RULE6, see RULE7

  property p_msb_first;
    @(posedge clk) disable iff (!rst_s_n)
    (pop && st_ff.depth == DEPTH_4BPP) |=> cur_idx == $past(pop_hi);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first pixel not top nibble"); // see RULE8, see RULE15

  property p_px_per_word;
    @(posedge clk) disable iff (!rst_s_n)
    pop |=> ({2'h0, st_ff.left} << st_ff.depth) == 7'h10;
  endproperty
  a_px_per_word: assert property (p_px_per_word) else $error("pixels per word wrong"); // see RULE13

  property p_line_step;
    @(posedge clk) disable iff (!rst_s_n)
    (issue && last_word && !frame_end) |=> st_ff.line_base == $past(step_target);
  endproperty
  a_line_step: assert property (p_line_step) else $error("line step wrong"); // see RULE14

  property p_mem_range;
    @(posedge clk) disable iff (!rst_s_n)
    mem_rd |-> 32'(mem_addr) < `MEM_WORDS;
  endproperty
  a_mem_range: assert property (p_mem_range) else $error("address beyond memory"); // see RULE12

  property p_extra_rw;
    @(posedge clk) disable iff (!rst_s_n)
    (bus.wr && bus.addr == `REG_LINE_EXTRA) ##1 (bus.rd && bus.addr == `REG_LINE_EXTRA)
    |=> rd_data == $past(bus.wdata, 2);
  endproperty
  a_extra_rw: assert property (p_extra_rw) else $error("extra words not read back"); // see RULE9

endmodule : gray_pixel_fetch

// ---- test/gray_panel_model.sv ----
`timescale 1ns/100ps

module gray_panel_model
  import gray_lut_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pace control
  input wire logic stall,
  // Pixel stream
  input wire logic pix_valid,
  output logic pix_ready
);
  // ----------------------------------------
  // Acceptance pacing
  // ----------------------------------------
  logic [2:0] pace_ff;

  // Slow panel takes one pixel in eight offered cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pace_ff <= 3'h0;
      pix_ready <= 1'b0;
    end
    else
    begin
      if (pix_valid)
      begin
        pace_ff <= pace_ff + 3'h1;
      end
      pix_ready <= !stall || (pace_ff == 3'h0);
    end
  end
endmodule : gray_panel_model

// ---- test/gray_pixel_fetch_tb_top.sv ----
`timescale 1ns/100ps

module gray_pixel_fetch_tb_top;
  import gray_lut_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_t bus = '0;
  logic [7:0] rd_data;
  logic mem_rd;
  logic [15:0] mem_addr;
  logic [15:0] mem_rdata = 16'h0000;
  logic pix_valid;
  logic pix_ready;
  logic stall = 1'b0;
  pixel_t pix;
  logic [3:0] green [16];
  int n_mismatch = 0;
  int checks = 0;
  int depth = 0;
  int extra = 0;
  int p = 0;
  int r = 0;
  int want = 0;

  always #4 clk = ~clk;

  gray_pixel_fetch #(.FIFO_DEPTH(8)) u_gray_pixel_fetch (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix(pix));

  gray_panel_model u_gray_panel_model (
    .clk(clk), .rst_n(rst_n), .stall(stall), .pix_valid(pix_valid),
    .pix_ready(pix_ready));

  // ----------------------------------------
  // Expected values
  // ----------------------------------------
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return {~a[7:0], a[7:0] ^ 8'hC5};
  endfunction : word_at

  // Two words per line, two lines per frame
  function automatic logic [15:0] addr_at(input int w);
    return 16'((w / 2) * (2 + extra) + w % 2);
  endfunction : addr_at

  function automatic pixel_t exp_pix(input int q);
    int bpp;
    int ppw;
    int k;
    int j;
    logic [15:0] d;
    logic [7:0] b;
    logic [3:0] idx;
    bpp = 1 << depth;
    ppw = 16 / bpp;
    k = q % ppw;
    d = word_at(addr_at(q / ppw));
    b = (k < ppw / 2) ? d[7:0] : d[15:8];
    j = k % (ppw / 2);
    idx = 4'((b >> (8 - bpp * (j + 1))) & ((1 << bpp) - 1));
    return {q == 0, (q % (2 * ppw)) == 2 * ppw - 1, green[idx]};
  endfunction : exp_pix

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally(input logic bad, input string msg);
    checks++;
    if (bad)
    begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : tally

  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    tally(rd_data !== exp, "register read data");
  endtask : rd

  // Write then read the same register with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    tally(rd_data !== d, "back to back read data");
  endtask : wr_rd

  task automatic run(input int d, input int x, input logic slow);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    depth = d;
    extra = x;
    p = 0;
    r = 0;
    want = (16 >> d) * 4;
    stall <= slow;
    repeat (3) @(posedge clk);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h01);
    wr(8'h11, 8'(x));
    for (int i = 0; i < 16; i++)
      wr(8'h20 + 8'(i), {green[i], 4'h9});
    wr(8'h00, {5'h00, 2'(d), 1'b1});
    n = 0;
    while (p < want && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (p < want)
      tally(1'b1, "pixel stream timeout");
  endtask : run

  // ----------------------------------------
  // Memory and stream monitors
  // ----------------------------------------
  always @(posedge clk)
    mem_rdata <= mem_rd ? word_at(mem_addr) : ~mem_rdata;

  always @(posedge clk)
  begin
    if (rst_n && mem_rd)
    begin
      tally(mem_addr !== addr_at(r % 4), "memory address");
      r = r + 1;
    end
    if (rst_n && pix_valid && pix_ready && p < want)
    begin
      tally(pix !== exp_pix(p), "pixel value");
      p = p + 1;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 16; i++)
      green[i] = 4'(15 - i);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h03, 8'h00);
    rd(8'h01, 8'h13);
    rd(8'h02, 8'hEF);
    rd(8'h11, 8'h00);
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'hFF);
    wr_rd(8'h11, 8'h28);
    wr(8'h40, 8'h5A);
    rd(8'h40, 8'h00);
    wr(8'h2F, 8'hAB);
    rd(8'h2F, 8'hA0);
    wr(8'h00, 8'h04);
    wr(8'h00, 8'h06);
    rd(8'h00, 8'h04);
    run(0, 0, 1'b0);
    run(1, 3, 1'b1);
    run(2, 255, 1'b1);
    complete_run();
  end
endmodule : gray_pixel_fetch_tb_top
